// >>> core/lsc_pkg.sv
// Package of constants for the bus slave control upper logic
package lsc_pkg;
   localparam logic [2:0] LSC_ADDR_CTRL = 3'h0;
   localparam logic [2:0] LSC_ADDR_CSUM = 3'h1;
   localparam logic [2:0] LSC_ADDR_BRK = 3'h3;
   localparam logic [2:0] LSC_ADDR_STAT = 3'h4;
   localparam logic [2:0] LSC_ADDR_IRQ = 3'h5;
   localparam logic [2:0] LSC_ADDR_MASK = 3'h6;
   localparam int LSC_B_MODE = 0;
   localparam int LSC_B_TXRDY_MSK = 1;
   localparam int LSC_B_EDGE_MSK = 5;
   localparam int LSC_B_COLL_MSK = 6;
   localparam int LSC_B_CLASSIC = 7;
   localparam int LSC_B_SEND_CS = 8;
   localparam int LSC_B_SYNC_TIM = 9;
   localparam int LSC_B_TEST_TX = 10;
   localparam int LSC_B_ENABLE = 11;
   localparam int LSC_B_BYPASS = 12;
   localparam logic [15:0] LSC_CTRL_RST = 16'h0000;
   localparam logic [15:0] LSC_CTRL_WMASK = 16'h1fff;
   localparam logic [18:0] LSC_BRK_RST = 19'h0157c;
   localparam logic [7:0] LSC_CSUM_RST = 8'hff;
   localparam int LSC_CLK_MHZ = 100;
   localparam int LSC_SYNC_LOW_CLKS = 750;
   localparam logic [9:0] LSC_SYNC_LOW_MAX = 10'(LSC_SYNC_LOW_CLKS);
   localparam logic [5:0] LSC_EDGE_MAX = 6'h39;
   // Interrupt status bits
   localparam int LSC_I_COLL = 0;
   localparam int LSC_I_EDGE = 1;
   localparam int LSC_I_SYNCBRK = 2;
   localparam int LSC_I_CSSENT = 3;
   localparam int LSC_NIRQ = 4;
endpackage : lsc_pkg

// >>> core/lsc_csum.sv
// Running LIN checksum accumulator with inverted readout
`timescale 1ns/1ps
`default_nettype none
module lsc_csum (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic clr,
   input wire logic byte_vld,
   input wire logic byte_is_pid,
   input wire logic classic,
   input wire logic [7:0] byte_val,
   output logic [7:0] csum_inv
);
   import lsc_pkg::*;
   logic [7:0] sum_q;
   logic [8:0] add;
   logic take;
   // Carry is folded back in, as a LIN checksum wants
   assign add = {1'b0, sum_q} + {1'b0, byte_val};
   // Classic sum leaves the identifier out
   assign take = byte_vld && !(byte_is_pid && classic);
   always_ff @(posedge mclk) begin
      if (!nrst || clr) begin
         sum_q <= 8'h00;
      end else if (take) begin
         sum_q <= add[7:0] + {7'h00, add[8]};
      end
   end
   assign csum_inv = ~sum_q;
endmodule : lsc_csum
`default_nettype wire

// >>> core/lsc_top.sv
// Upper control register logic of the LIN slave interface
// Notes on behaviour
// - Bypass bit hands the transceiver to software alone.
// - Enable bit runs interface; clearing resets interface state.
// - Test-transmit bit allows sending without a received header.
// - Sync start bit low over 750 clocks counts as new break.
// - Send-checksum transmits checksum, then hardware clears the bit.
// - Checksum type bit: one classic without identifier, zero enhanced.
// - Changing checksum type during a frame resets the running checksum.
// - Mask clear: every collision sets flag and interrupts.
// - Mask set: collisions after transmit finished are dropped.
// - Mask set: collisions before transmit finished still flagged.
// - Over 57 falling edges per frame raises edge error unless masked.
// - Break limit register resets to 5500 clocks.
// - Checksum register holds inverted sum; correct frame reads zero.
// - Mode bit set by software, cleared by hardware on break.
// - Setting send-checksum also sets transmit-ready interrupt mask.
`timescale 1ns/1ps
`default_nettype none
module lsc_top (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [2:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   input wire logic rx_pin,
   input wire logic sw_tx,
   input wire logic proto_tx,
   input wire logic brk_rcvd,
   input wire logic frame_start,
   input wire logic hdr_done,
   input wire logic byte_vld,
   input wire logic byte_is_pid,
   input wire logic [7:0] byte_val,
   input wire logic cs_sent,
   input wire logic coll_det,
   input wire logic tx_done,
   input wire logic txrdy,
   output logic xcvr_tx,
   output logic if_run,
   output logic tx_allow,
   output logic cs_send_req,
   output logic sync_brk,
   output logic [15:0] ctrl_out,
   output logic [18:0] brk_limit,
   output logic irq
);
   import lsc_pkg::*;
   logic rx_s1_q, rx_s2_q, rx_s3_q;
   logic [15:0] ctrl_q, ctrl_d;
   logic [18:0] brk_q;
   logic [LSC_NIRQ-1:0] ist_q, imsk_q, iset;
   logic [5:0] edge_cnt_q;
   logic [9:0] low_cnt_q;
   logic in_sync_q, edge_err_q, classic_q, coll_ok;
   logic [7:0] csum_inv;
   logic [15:0] rdata_q;
   logic xcvr_q, run_q, allow_q, csreq_q, sbrk_q, irq_q;
   wire wr_ctrl = wr && addr == LSC_ADDR_CTRL;
   wire wr_brk = wr && addr == LSC_ADDR_BRK;
   wire wr_irq = wr && addr == LSC_ADDR_IRQ;
   wire wr_msk = wr && addr == LSC_ADDR_MASK;
   wire en = ctrl_q[LSC_B_ENABLE];
   wire fall = rx_s3_q && !rx_s2_q;
   wire sync_over = ctrl_q[LSC_B_SYNC_TIM] && in_sync_q && !rx_s2_q
                    && low_cnt_q == LSC_SYNC_LOW_MAX;
   wire edge_over = en && fall && edge_cnt_q == LSC_EDGE_MAX && !edge_err_q;
   wire cs_type_chg = en && ctrl_q[LSC_B_CLASSIC] != classic_q;
   wire [15:0] rmux = (addr == LSC_ADDR_CTRL) ? ctrl_q :
                      (addr == LSC_ADDR_CSUM) ? {8'h00, csum_inv} :
                      (addr == LSC_ADDR_BRK) ? brk_q[15:0] :
                      (addr == LSC_ADDR_STAT) ? {13'h0000, brk_q[18:16]} :
                      (addr == LSC_ADDR_IRQ) ? {12'h000, ist_q} :
                      (addr == LSC_ADDR_MASK) ? {12'h000, imsk_q} : 16'h0000;
   // Only the two synchronised stages feed the edge logic
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         rx_s1_q <= 1'b1;
         rx_s2_q <= 1'b1;
         rx_s3_q <= 1'b1;
      end else begin
         rx_s1_q <= rx_pin;
         rx_s2_q <= rx_s1_q;
         rx_s3_q <= rx_s2_q;
      end
   end
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_ctrl) begin
         ctrl_d = wdata & LSC_CTRL_WMASK;
         if (wdata[LSC_B_SEND_CS]) begin
            ctrl_d[LSC_B_TXRDY_MSK] = 1'b1;
         end
      end
      // Hardware clears win over a same-cycle software write
      if (en && cs_sent) begin
         ctrl_d[LSC_B_SEND_CS] = 1'b0;
      end
      if (en && (brk_rcvd || sync_over)) begin
         ctrl_d[LSC_B_MODE] = 1'b0;
      end
   end
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ctrl_q <= LSC_CTRL_RST;
         brk_q <= LSC_BRK_RST;
         classic_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         classic_q <= ctrl_q[LSC_B_CLASSIC];
         if (wr_brk) begin
            brk_q <= {3'h0, wdata};
         end
      end
   end
   // Sync first-bit timer, active from header start until the first rise
   always_ff @(posedge mclk) begin
      if (!nrst || !en || frame_start || brk_rcvd) begin
         in_sync_q <= nrst && en && frame_start;
         low_cnt_q <= 10'h000;
      end else if (in_sync_q) begin
         if (rx_s2_q && low_cnt_q != 10'h000) begin
            in_sync_q <= 1'b0;
         end else if (!rx_s2_q && low_cnt_q != LSC_SYNC_LOW_MAX) begin
            low_cnt_q <= low_cnt_q + 10'h001;
         end else if (sync_over) begin
            in_sync_q <= 1'b0;
         end
      end
   end
   always_ff @(posedge mclk) begin
      if (!nrst || !en || frame_start || brk_rcvd) begin
         edge_cnt_q <= 6'h00;
         edge_err_q <= 1'b0;
      end else if (fall) begin
         if (edge_cnt_q != LSC_EDGE_MAX) begin
            edge_cnt_q <= edge_cnt_q + 6'h01;
         end else begin
            edge_err_q <= 1'b1;
         end
      end
   end
   // Collisions after transmit finished are dropped only when masked
   assign coll_ok = coll_det && (!ctrl_q[LSC_B_COLL_MSK] || !tx_done);
   assign iset[LSC_I_COLL] = en && coll_ok;
   assign iset[LSC_I_EDGE] = edge_over && !ctrl_q[LSC_B_EDGE_MSK];
   assign iset[LSC_I_SYNCBRK] = en && sync_over;
   assign iset[LSC_I_CSSENT] = en && cs_sent;
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ist_q <= '0;
         imsk_q <= '0;
      end else begin
         // Set wins over write-one-to-clear
         ist_q <= (ist_q & ~(wr_irq ? wdata[LSC_NIRQ-1:0] : '0)) | iset;
         if (wr_msk) begin
            imsk_q <= wdata[LSC_NIRQ-1:0];
         end
      end
   end
   lsc_csum u_csum (
      .mclk(mclk),
      .nrst(nrst),
      .clr(!en || frame_start || cs_type_chg),
      .byte_vld(en && byte_vld),
      .byte_is_pid(byte_is_pid),
      .classic(ctrl_q[LSC_B_CLASSIC]),
      .byte_val(byte_val),
      .csum_inv(csum_inv)
   );
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         rdata_q <= 16'h0000;
         xcvr_q <= 1'b1;
         run_q <= 1'b0;
         allow_q <= 1'b0;
         csreq_q <= 1'b0;
         sbrk_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         rdata_q <= rd ? rmux : 16'h0000;
         xcvr_q <= ctrl_q[LSC_B_BYPASS] ? sw_tx : (en ? proto_tx : 1'b1);
         run_q <= en;
         allow_q <= en && ctrl_q[LSC_B_MODE] && (hdr_done || ctrl_q[LSC_B_TEST_TX]);
         // Request only once software had transmit ready, as it must
         csreq_q <= en && ctrl_q[LSC_B_SEND_CS] && txrdy && !cs_sent;
         sbrk_q <= sync_over;
         irq_q <= |(ist_q & ~imsk_q);
      end
   end
   assign rdata = rdata_q;
   assign xcvr_tx = xcvr_q;
   assign if_run = run_q;
   assign tx_allow = allow_q;
   assign cs_send_req = csreq_q;
   assign sync_brk = sbrk_q;
   assign ctrl_out = ctrl_q;
   assign brk_limit = brk_q;
   assign irq = irq_q;

   a_bypass_pass: assert property (@(posedge mclk) disable iff (!nrst)
      ctrl_q[LSC_B_BYPASS] |=> xcvr_tx == $past(sw_tx))
      else $error("bypass does not pass software level");
   a_disable_reset: assert property (@(posedge mclk) disable iff (!nrst)
      !en |=> edge_cnt_q == 6'h00 && !in_sync_q && !if_run)
      else $error("disabled interface keeps state");
   sequence s_sync_low;
      in_sync_q && !rx_s2_q && ctrl_q[LSC_B_SYNC_TIM] && en;
   endsequence
   a_sync_break: assert property (@(posedge mclk) disable iff (!nrst)
      s_sync_low and (low_cnt_q == LSC_SYNC_LOW_MAX) |=> !in_sync_q && sync_brk)
      else $error("long sync start bit not taken as break");
   a_send_clear: assert property (@(posedge mclk) disable iff (!nrst)
      en && cs_sent |=> !ctrl_q[LSC_B_SEND_CS])
      else $error("send checksum bit not cleared");
   a_type_reset: assert property (@(posedge mclk) disable iff (!nrst)
      cs_type_chg |=> csum_inv == 8'hff)
      else $error("checksum not reset on type change");
   a_coll_masked: assert property (@(posedge mclk) disable iff (!nrst)
      coll_det && tx_done && ctrl_q[LSC_B_COLL_MSK] && !ist_q[LSC_I_COLL] && !wr_irq
      |=> !ist_q[LSC_I_COLL])
      else $error("masked late collision flagged");
   a_coll_flag: assert property (@(posedge mclk) disable iff (!nrst)
      en && coll_det && (!tx_done || !ctrl_q[LSC_B_COLL_MSK]) |=> ist_q[LSC_I_COLL])
      else $error("collision not flagged");
   a_edge_err: assert property (@(posedge mclk) disable iff (!nrst)
      edge_over && !ctrl_q[LSC_B_EDGE_MSK] |=> ist_q[LSC_I_EDGE])
      else $error("edge overflow not flagged");
   a_mode_clear: assert property (@(posedge mclk) disable iff (!nrst)
      en && brk_rcvd |=> !ctrl_q[LSC_B_MODE])
      else $error("mode bit survives break");
   a_txrdy_mask: assert property (@(posedge mclk) disable iff (!nrst)
      wr_ctrl && wdata[LSC_B_SEND_CS] |=> ctrl_q[LSC_B_TXRDY_MSK])
      else $error("transmit ready mask not set");
   a_reserved_zero: assert property (@(posedge mclk) disable iff (!nrst)
      ctrl_q[15:13] == 3'h0)
      else $error("reserved control bits set");

   // Transceiver drive and run gating
   a_normal_drive: assert property (@(posedge mclk) disable iff (!nrst)
      en && !ctrl_q[LSC_B_BYPASS] |=> xcvr_tx == $past(proto_tx))
      else $error("protocol level not driven");
   a_idle_drive: assert property (@(posedge mclk) disable iff (!nrst)
      !en && !ctrl_q[LSC_B_BYPASS] |=> xcvr_tx)
      else $error("idle transceiver not recessive");
   a_run_follow: assert property (@(posedge mclk) disable iff (!nrst)
      en |=> if_run)
      else $error("enabled interface not running");
   a_run_stop: assert property (@(posedge mclk) disable iff (!nrst)
      !en |=> !tx_allow && !cs_send_req)
      else $error("disabled interface still sends");
   a_test_allow: assert property (@(posedge mclk) disable iff (!nrst)
      en && ctrl_q[LSC_B_MODE] && ctrl_q[LSC_B_TEST_TX] |=> tx_allow)
      else $error("test transmit not allowed");
   a_hdr_gate: assert property (@(posedge mclk) disable iff (!nrst)
      !ctrl_q[LSC_B_TEST_TX] && !hdr_done |=> !tx_allow)
      else $error("transmit allowed without header");

   // Frame timing and counters
   a_sync_start: assert property (@(posedge mclk) disable iff (!nrst)
      en && frame_start |=> in_sync_q && low_cnt_q == 10'h000)
      else $error("sync timer not started");
   a_sync_off: assert property (@(posedge mclk) disable iff (!nrst)
      !ctrl_q[LSC_B_SYNC_TIM] |=> !sync_brk)
      else $error("sync break with timing off");
   a_edge_reset: assert property (@(posedge mclk) disable iff (!nrst)
      frame_start |=> edge_cnt_q == 6'h00 && !edge_err_q)
      else $error("edge count not cleared at frame start");
   a_edge_count: assert property (@(posedge mclk) disable iff (!nrst)
      en && fall && edge_cnt_q != LSC_EDGE_MAX && !frame_start && !brk_rcvd
      |=> edge_cnt_q == $past(edge_cnt_q) + 6'h01)
      else $error("falling edge not counted");
   a_edge_masked: assert property (@(posedge mclk) disable iff (!nrst)
      edge_over && ctrl_q[LSC_B_EDGE_MSK] && !ist_q[LSC_I_EDGE] |=> !ist_q[LSC_I_EDGE])
      else $error("masked edge overflow flagged");
   a_brk_write: assert property (@(posedge mclk) disable iff (!nrst)
      wr_brk |=> brk_limit == {3'h0, $past(wdata)})
      else $error("break limit write lost");

   // Checksum, control bits and interrupts
   a_csum_clear: assert property (@(posedge mclk) disable iff (!nrst)
      frame_start |=> csum_inv == 8'hff)
      else $error("checksum not cleared at frame start");
   a_classic_skip: assert property (@(posedge mclk) disable iff (!nrst)
      en && byte_vld && byte_is_pid && ctrl_q[LSC_B_CLASSIC] && !frame_start && !cs_type_chg
      |=> $stable(csum_inv))
      else $error("classic checksum took identifier");
   sequence s_cs_armed;
      en && ctrl_q[LSC_B_SEND_CS] && txrdy && !cs_sent;
   endsequence
   a_send_req: assert property (@(posedge mclk) disable iff (!nrst)
      s_cs_armed |=> cs_send_req)
      else $error("checksum send not requested");
   a_send_hold: assert property (@(posedge mclk) disable iff (!nrst)
      ctrl_q[LSC_B_SEND_CS] && !cs_sent && !wr_ctrl |=> ctrl_q[LSC_B_SEND_CS])
      else $error("send checksum bit dropped early");
   a_sent_flag: assert property (@(posedge mclk) disable iff (!nrst)
      en && cs_sent |=> ist_q[LSC_I_CSSENT])
      else $error("checksum sent not flagged");
   // A break in the same cycle must still win over the software set
   a_mode_sw: assert property (@(posedge mclk) disable iff (!nrst)
      wr_ctrl && wdata[LSC_B_MODE] && !brk_rcvd && !sync_over |=> ctrl_q[LSC_B_MODE])
      else $error("mode bit write lost");
endmodule : lsc_top
`default_nettype wire

// >>> testbench/lsc_master_model.sv
// Far-end bus master model driving the receive line of the slave
`timescale 1ns/1ps
`default_nettype none
module lsc_master_model (
   input wire logic mclk,
   output logic rx_pin
);
   // Bus has a pull-up, so the released line sits recessive high
   initial rx_pin = 1'b1;
   task automatic hold_low(input int n);
      @(posedge mclk) rx_pin <= 1'b0;
      repeat (n) @(posedge mclk);
      rx_pin <= 1'b1;
   endtask : hold_low
   // Two-cycle low and three-cycle high phases stay well clear of the two-flop receive sync
   task automatic falls(input int n);
      repeat (n) begin
         @(posedge mclk) rx_pin <= 1'b0;
         repeat (2) @(posedge mclk);
         rx_pin <= 1'b1;
         repeat (2) @(posedge mclk);
      end
   endtask : falls
endmodule : lsc_master_model
`default_nettype wire

// >>> testbench/lsc_top_bench.sv
// Self-checking bench for the upper control logic of the bus slave
`timescale 1ns/1ps
`default_nettype none
module lsc_top_bench;
   import lsc_pkg::*;
   logic mclk, nrst, wr, rd, sw_tx, proto_tx, hdr_done, byte_is_pid, tx_done, txrdy;
   logic sb_seen;
   logic [2:0] addr;
   logic [15:0] wdata, v;
   logic [7:0] byte_val;
   logic [4:0] ev;
   wire [15:0] rdata, ctrl_out;
   wire [18:0] brk_limit;
   wire rx_pin, xcvr_tx, if_run, tx_allow, cs_send_req, sync_brk, irq;
   int fails, comparisons, cyc;
   logic [15:0] rw [5] = '{16'he000, 16'h1800, 16'h0800, 16'h0900, 16'h0080};
   logic [15:0] re [5] = '{16'h0000, 16'h1800, 16'h0800, 16'h0902, 16'h0080};
   logic [4:0] rr = 5'b01110;
   logic [4:0] rt = 5'b11101;
   lsc_master_model mdl_u (.mclk(mclk), .rx_pin(rx_pin));
   lsc_top dut_u (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .rx_pin(rx_pin), .sw_tx(sw_tx), .proto_tx(proto_tx),
      .brk_rcvd(ev[0]), .frame_start(ev[1]), .hdr_done(hdr_done), .byte_vld(ev[2]),
      .byte_is_pid(byte_is_pid), .byte_val(byte_val), .cs_sent(ev[3]), .coll_det(ev[4]),
      .tx_done(tx_done), .txrdy(txrdy), .xcvr_tx(xcvr_tx), .if_run(if_run),
      .tx_allow(tx_allow), .cs_send_req(cs_send_req), .sync_brk(sync_brk),
      .ctrl_out(ctrl_out), .brk_limit(brk_limit), .irq(irq));
   task automatic chk(input logic [18:0] seen, input logic [18:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
      @(posedge mclk) addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk) wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
      @(posedge mclk) addr <= a;
      rd <= 1'b1;
      @(posedge mclk) rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg
   task automatic pls(input int i);
      @(posedge mclk) ev[i] <= 1'b1;
      @(posedge mclk) ev[i] <= 1'b0;
   endtask : pls
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : step
   task automatic byte_in(input logic p, input logic [7:0] b);
      byte_is_pid <= p;
      byte_val <= b;
      pls(2);
   endtask : byte_in
   task automatic stop_test();
      $display("checks %0d mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Catch the one-cycle sync break pulse wherever it lands
   always @(posedge mclk) begin
      if (sync_brk === 1'b1) begin
         sb_seen <= 1'b1;
      end
   end
   // Whole run needs well under half of this ceiling
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 12000) begin
         fails++;
         stop_test();
      end
   end
   initial begin
      {nrst, wr, rd, hdr_done, byte_is_pid, tx_done, txrdy, sw_tx} = '0;
      proto_tx = 1'b1;
      sb_seen = 1'b0;
      addr = '0;
      wdata = '0;
      byte_val = '0;
      ev = '0;
      repeat (6) @(posedge mclk);
      nrst <= 1'b1;
      rd_reg(LSC_ADDR_CTRL, v);
      chk(v, 16'h0000);
      rd_reg(LSC_ADDR_BRK, v);
      chk(v, 16'h157c);
      chk(brk_limit, 19'h0157c);
      rd_reg(LSC_ADDR_CSUM, v);
      chk(v, 16'h00ff);
      chk(xcvr_tx, 1'b1);
      $display("test reset done");
      for (int i = 0; i < 5; i++) begin
         wr_reg(LSC_ADDR_CTRL, rw[i]);
         rd_reg(LSC_ADDR_CTRL, v);
         chk(v, re[i]);
         chk(if_run, rr[i]);
         chk(xcvr_tx, rt[i]);
      end
      wr_reg(3'h2, 16'hffff);
      rd_reg(3'h2, v);
      chk(v, 16'h0000);
      $display("test table done");
      wr_reg(LSC_ADDR_CTRL, 16'h0800);
      pls(1);
      byte_in(1'b1, 8'h42);
      byte_in(1'b0, 8'h10);
      rd_reg(LSC_ADDR_CSUM, v);
      chk(v, 16'h00ad);
      byte_in(1'b0, 8'had);
      rd_reg(LSC_ADDR_CSUM, v);
      chk(v, 16'h0000);
      wr_reg(LSC_ADDR_CTRL, 16'h0880);
      pls(1);
      byte_in(1'b1, 8'h42);
      byte_in(1'b0, 8'h10);
      rd_reg(LSC_ADDR_CSUM, v);
      chk(v, 16'h00ef);
      wr_reg(LSC_ADDR_CTRL, 16'h0800);
      rd_reg(LSC_ADDR_CSUM, v);
      chk(v, 16'h00ff);
      byte_in(1'b0, 8'h10);
      wr_reg(LSC_ADDR_CTRL, 16'h0000);
      rd_reg(LSC_ADDR_CSUM, v);
      chk(v, 16'h00ff);
      $display("test checksum done");
      txrdy <= 1'b1;
      wr_reg(LSC_ADDR_CTRL, 16'h0900);
      step(2);
      chk(cs_send_req, 1'b1);
      pls(3);
      step(1);
      chk(cs_send_req, 1'b0);
      rd_reg(LSC_ADDR_CTRL, v);
      chk(v, 16'h0802);
      rd_reg(LSC_ADDR_IRQ, v);
      chk(v[LSC_I_CSSENT], 1'b1);
      chk(irq, 1'b1);
      wr_reg(LSC_ADDR_MASK, 16'h0008);
      step(2);
      chk(irq, 1'b0);
      wr_reg(LSC_ADDR_MASK, 16'h0000);
      wr_reg(LSC_ADDR_IRQ, 16'h000f);
      txrdy <= 1'b0;
      step(2);
      chk(irq, 1'b0);
      $display("test send checksum done");
      for (int k = 0; k < 3; k++) begin
         wr_reg(LSC_ADDR_CTRL, (k > 0) ? 16'h0840 : 16'h0800);
         tx_done <= (k != 2);
         pls(4);
         rd_reg(LSC_ADDR_IRQ, v);
         chk(v[LSC_I_COLL], k != 1);
         wr_reg(LSC_ADDR_IRQ, 16'h000f);
      end
      $display("test collision done");
      wr_reg(LSC_ADDR_CTRL, 16'h0800);
      pls(1);
      mdl_u.falls(57);
      step(4);
      rd_reg(LSC_ADDR_IRQ, v);
      chk(v[LSC_I_EDGE], 1'b0);
      mdl_u.falls(1);
      step(4);
      rd_reg(LSC_ADDR_IRQ, v);
      chk(v[LSC_I_EDGE], 1'b1);
      wr_reg(LSC_ADDR_IRQ, 16'h000f);
      wr_reg(LSC_ADDR_CTRL, 16'h0820);
      pls(1);
      mdl_u.falls(58);
      step(4);
      rd_reg(LSC_ADDR_IRQ, v);
      chk(v[LSC_I_EDGE], 1'b0);
      $display("test edge count done");
      for (int k = 0; k < 3; k++) begin
         wr_reg(LSC_ADDR_CTRL, (k > 0) ? 16'h0a00 : 16'h0800);
         sb_seen <= 1'b0;
         pls(1);
         mdl_u.hold_low((k == 2) ? 700 : 800);
         step(4);
         rd_reg(LSC_ADDR_IRQ, v);
         chk(v[LSC_I_SYNCBRK], k == 1);
         chk(sb_seen, k == 1);
         wr_reg(LSC_ADDR_IRQ, 16'h000f);
      end
      $display("test sync timing done");
      wr_reg(LSC_ADDR_CTRL, 16'h0801);
      step(2);
      chk(tx_allow, 1'b0);
      hdr_done <= 1'b1;
      step(2);
      chk(tx_allow, 1'b1);
      hdr_done <= 1'b0;
      wr_reg(LSC_ADDR_CTRL, 16'h0c01);
      step(2);
      chk(tx_allow, 1'b1);
      pls(0);
      rd_reg(LSC_ADDR_CTRL, v);
      chk(v, 16'h0c00);
      chk(ctrl_out, 16'h0c00);
      $display("test mode done");
      wr_reg(LSC_ADDR_BRK, 16'h1234);
      rd_reg(LSC_ADDR_STAT, v);
      chk(brk_limit, 19'h01234);
      chk(v, 16'h0000);
      @(posedge mclk) nrst <= 1'b0;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      rd_reg(LSC_ADDR_CTRL, v);
      chk(v, 16'h0000);
      chk(brk_limit, 19'h0157c);
      chk(if_run, 1'b0);
      $display("test mid reset done");
      stop_test();
   end
endmodule : lsc_top_bench
`default_nettype wire
